//--- common/pltw_pkg.sv
// Constants and types for the program memory long write controller
package pltw_pkg;

  // ****************************************
  // Core interrupt sources, highest priority first
  // ****************************************
  localparam int CORE_SRC_N = 3;
  localparam int SRC_EXT_PIN = 0;
  localparam int SRC_TIMER0_OVERFLOW_SOURCE_OVF = 1;
  localparam int SRC_TIMER0_OVERFLOW_SOURCE_CKI = 2;

  // ****************************************
  // Timing and reset values
  // ****************************************
  localparam logic [1:0] SHORT_WRITE_CYCLES = 2'h2;
  localparam logic [1:0] SHORT_CNT_RESET = 2'h0;
  localparam logic [2:0] VPP_SYNC_RESET = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LONG_WRITE,
    ST_SHORT_WRITE
  } pltw_state_t;

endpackage

//--- common/pltw_prio_if.sv
// Interface between the controller and the core source priority picker
`timescale 1ns/1ps
interface pltw_prio_if;
  import pltw_pkg::*;

  logic [CORE_SRC_N-1:0] enable;
  logic [CORE_SRC_N-1:0] flag;
  logic [CORE_SRC_N-1:0] select;
  logic                  any;

  modport ctrl (output enable, output flag, input select, input any);
  modport prio (input enable, input flag, output select, output any);
endinterface

//--- core/pltw_prio.sv
// Priority picker for the core interrupt sources
`timescale 1ns/1ps
module pltw_prio (
  pltw_prio_if.prio pif
);
  import pltw_pkg::*;

  logic [CORE_SRC_N-1:0] pend;
  logic [CORE_SRC_N:0]   higher;

  // ****************************************
  // One-hot pick of the first pending source
  // ****************************************
  assign higher[0] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < CORE_SRC_N; i++) begin : g_src
      assign pend[i]       = pif.enable[i] & pif.flag[i];
      assign pif.select[i] = pend[i] & ~higher[i];
      assign higher[i+1]   = higher[i] | pend[i];
    end
  endgenerate

  assign pif.any = higher[CORE_SRC_N];
endmodule // pltw_prio

//--- core/pltw_ctrl.sv
// Long write control for table writes into internal program memory
`timescale 1ns/1ps
// Summary of operation
// - Table write starts long write, halting execution
// - Only enabled interrupt or reset ends it
// - Source ends write only if enabled and flagged
// - Global disable never gates termination
// - Global disable clear vectors, set does not
// - Core source ending write gets flag cleared
// - Core source, disable clear: vector, clear flag
// - Core source, disable set: resume, clear flag
// - Peripheral flag stays set, even when vectoring
// - Peripheral, disable set: resume, flag kept
// - Pending interrupt at issue: write becomes no-op
// - No programming voltage: two-cycle write, no change
module pltw_ctrl #(
  parameter int PERIPH_N = 16
) (
  input  wire logic                              REF_CLK,
  input  wire logic                              SYS_RST,
  input  wire logic                              TABLE_WRITE_INSTR,
  input  wire logic                              CLEAR_PROGRAM_VOLTAGE_PIN,
  input  wire logic                              GLOBAL_INTERRUPT_DISABLE,
  input  wire logic [pltw_pkg::CORE_SRC_N-1:0]   CORE_INT_ENABLE,
  input  wire logic [pltw_pkg::CORE_SRC_N-1:0]   CORE_INT_FLAG,
  input  wire logic [PERIPH_N-1:0]               PERIPH_INT_ENABLE,
  input  wire logic [PERIPH_N-1:0]               PERIPH_INT_FLAG,
  output logic                                   EXEC_HALT,
  output logic                                   PROG_WRITE_ENABLE,
  output logic                                   WRITE_DONE,
  output logic                                   VECTOR_REQ,
  output logic                                   RESUME_NEXT,
  output logic                                   WRITE_ABORTED,
  output logic [pltw_pkg::CORE_SRC_N-1:0]        CORE_FLAG_CLEAR
);
  import pltw_pkg::*;

  pltw_prio_if pif ();

  pltw_state_t           state_reg, state_next;
  logic [1:0]            short_cnt_reg, short_cnt_next;
  logic [2:0]            vpp_sync_reg;
  logic                  vpp_ok_reg;
  logic                  done_reg, vector_reg, resume_reg, abort_reg;
  logic [CORE_SRC_N-1:0] clear_reg;

  // ****************************************
  // Pending source decode
  // ****************************************
  assign pif.enable = CORE_INT_ENABLE;
  assign pif.flag   = CORE_INT_FLAG;

  pltw_prio u_prio (
    .pif (pif)
  );

  wire periph_any = |(PERIPH_INT_ENABLE & PERIPH_INT_FLAG);
  wire pend_any   = pif.any | periph_any;
  wire in_idle    = (state_reg == ST_IDLE);
  wire in_long    = (state_reg == ST_LONG_WRITE);
  wire in_short   = (state_reg == ST_SHORT_WRITE);
  wire start_req  = in_idle & TABLE_WRITE_INSTR;
  wire abort_now  = start_req & pend_any;
  wire start_long = start_req & ~pend_any & vpp_ok_reg;
  wire start_shrt = start_req & ~pend_any & ~vpp_ok_reg;
  wire end_long   = in_long & pend_any;
  wire end_short  = in_short & (short_cnt_reg == SHORT_WRITE_CYCLES - 2'h1);
  wire vector_now = end_long & ~GLOBAL_INTERRUPT_DISABLE;
  wire resume_now = (end_long & GLOBAL_INTERRUPT_DISABLE) | end_short;
  wire clear_now  = end_long | abort_now;
  // Peripheral flags are never touched; only core picks clear
  wire [CORE_SRC_N-1:0] clear_sel = clear_now ? pif.select : '0;

  // ****************************************
  // Programming voltage synchroniser
  // ****************************************
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      vpp_sync_reg <= VPP_SYNC_RESET;
    end else begin
      vpp_sync_reg <= {vpp_sync_reg[1:0], CLEAR_PROGRAM_VOLTAGE_PIN};
    end
  end

  // Level accepted once second and third stages agree
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      vpp_ok_reg <= 1'b0;
    end else if (vpp_sync_reg[1] == vpp_sync_reg[2]) begin
      vpp_ok_reg <= vpp_sync_reg[2];
    end
  end

  // ****************************************
  // Write sequencer
  // ****************************************
  always_comb begin
    state_next     = state_reg;
    short_cnt_next = SHORT_CNT_RESET;
    case (state_reg)
      ST_IDLE: begin
        if (start_long) begin
          state_next = ST_LONG_WRITE;
        end else if (start_shrt) begin
          state_next = ST_SHORT_WRITE;
        end
      end
      ST_LONG_WRITE: begin
        if (end_long) begin
          state_next = ST_IDLE;
        end
      end
      ST_SHORT_WRITE: begin
        if (end_short) begin
          state_next = ST_IDLE;
        end else begin
          short_cnt_next = short_cnt_reg + 2'h1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg     <= ST_IDLE;
      short_cnt_reg <= SHORT_CNT_RESET;
    end else begin
      state_reg     <= state_next;
      short_cnt_reg <= short_cnt_next;
    end
  end

  // ****************************************
  // Completion pulses
  // ****************************************
  always_ff @(posedge REF_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      done_reg   <= 1'b0;
      vector_reg <= 1'b0;
      resume_reg <= 1'b0;
      abort_reg  <= 1'b0;
      clear_reg  <= '0;
    end else begin
      done_reg   <= end_long | end_short;
      vector_reg <= vector_now;
      resume_reg <= resume_now;
      abort_reg  <= abort_now;
      clear_reg  <= clear_sel;
    end
  end

  assign EXEC_HALT         = ~in_idle;
  assign PROG_WRITE_ENABLE = in_long;
  assign WRITE_DONE        = done_reg;
  assign VECTOR_REQ        = vector_reg;
  assign RESUME_NEXT       = resume_reg;
  assign WRITE_ABORTED     = abort_reg;
  assign CORE_FLAG_CLEAR   = clear_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_short_start;
    in_idle && TABLE_WRITE_INSTR && !pend_any && !vpp_ok_reg;
  endsequence

  sequence s_short_body;
    (EXEC_HALT && !PROG_WRITE_ENABLE) [*2] ##1 (!EXEC_HALT && RESUME_NEXT);
  endsequence

  sequence s_long_end;
    in_long && pend_any;
  endsequence

  a_halt_long_write: assert property (start_long |=> EXEC_HALT && PROG_WRITE_ENABLE)
    else $error("Long write did not halt execution");
  a_only_irq_end: assert property (in_long && !pend_any |=> in_long && EXEC_HALT)
    else $error("Long write ended without interrupt");
  a_needs_en_flag: assert property (s_long_end |=> !EXEC_HALT && WRITE_DONE)
    else $error("Enabled flagged source did not end write");
  a_gid_no_gate: assert property (end_long && GLOBAL_INTERRUPT_DISABLE |=> !in_long)
    else $error("Global disable gated termination");
  a_vector_clear: assert property (end_long && !GLOBAL_INTERRUPT_DISABLE |=> VECTOR_REQ && !RESUME_NEXT)
    else $error("No vector with global disable clear");
  a_core_vec_clr: assert property (end_long && pif.any && !GLOBAL_INTERRUPT_DISABLE
                                    |=> VECTOR_REQ && CORE_FLAG_CLEAR == $past(pif.select))
    else $error("Core vector did not clear flag");
  a_core_novec_clr: assert property (end_long && pif.any && GLOBAL_INTERRUPT_DISABLE
                                      |=> !VECTOR_REQ && RESUME_NEXT && $onehot(CORE_FLAG_CLEAR))
    else $error("Core termination without vector mishandled");
  a_core_pick_clr: assert property (end_long && pif.any |=> CORE_FLAG_CLEAR == $past(pif.select))
    else $error("Wrong core flag cleared");
  a_periph_kept: assert property (end_long && !pif.any |=> CORE_FLAG_CLEAR == '0)
    else $error("Flag cleared for peripheral termination");
  a_periph_resume: assert property (end_long && !pif.any && GLOBAL_INTERRUPT_DISABLE
                                     |=> RESUME_NEXT && !VECTOR_REQ && CORE_FLAG_CLEAR == '0)
    else $error("Peripheral termination without vector mishandled");
  a_pending_nop: assert property (abort_now |=> WRITE_ABORTED && !EXEC_HALT
                                   && CORE_FLAG_CLEAR == $past(pif.select))
    else $error("Pending interrupt did not abort write");
  a_short_write: assert property (s_short_start |=> s_short_body)
    else $error("Short write timing wrong");
  a_resume_next: assert property (RESUME_NEXT |-> !VECTOR_REQ && !EXEC_HALT)
    else $error("Resume overlaps vector or halt");
endmodule // pltw_ctrl

//--- bench/pltw_irq_model.sv
// Model of the interrupt flag logic that surrounds the controller
`timescale 1ns/1ps
module pltw_irq_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [2:0]  core_set,
  input  wire logic [15:0] per_set,
  input  wire logic        wipe,
  input  wire logic [2:0]  flag_clr,
  output logic      [2:0]  core_flag,
  output logic      [15:0] per_flag
);
  // Flags stay set until cleared by the controller or by software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_flag <= 3'h0;
      per_flag  <= 16'h0000;
    end else if (wipe) begin
      core_flag <= 3'h0;
      per_flag  <= 16'h0000;
    end else begin
      core_flag <= (core_flag | core_set) & ~flag_clr;
      per_flag  <= per_flag | per_set;
    end
  end
endmodule // pltw_irq_model

//--- bench/testbench.sv
// Self-checking bench for the long write controller
`timescale 1ns/1ps
module testbench;
  import pltw_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        instr = 1'b0;
  logic        vpp = 1'b0;
  logic        gid = 1'b0;
  logic [2:0]  ce = 3'h0;
  logic [15:0] pe = 16'h0000;
  logic [2:0]  cs = 3'h0;
  logic [15:0] ps = 16'h0000;
  logic        wipe = 1'b0;
  logic [2:0]  cf, clr;
  logic [15:0] pf;
  logic        halt, pwe, done, vec, res, abt;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cycles = 0;

  pltw_ctrl #(.PERIPH_N(16)) u_pltw_ctrl (
    .REF_CLK(clk), .SYS_RST(rst), .TABLE_WRITE_INSTR(instr),
    .CLEAR_PROGRAM_VOLTAGE_PIN(vpp), .GLOBAL_INTERRUPT_DISABLE(gid),
    .CORE_INT_ENABLE(ce), .CORE_INT_FLAG(cf), .PERIPH_INT_ENABLE(pe),
    .PERIPH_INT_FLAG(pf), .EXEC_HALT(halt), .PROG_WRITE_ENABLE(pwe),
    .WRITE_DONE(done), .VECTOR_REQ(vec), .RESUME_NEXT(res),
    .WRITE_ABORTED(abt), .CORE_FLAG_CLEAR(clr));

  pltw_irq_model u_pltw_irq_model (
    .clk(clk), .rst(rst), .core_set(cs), .per_set(ps), .wipe(wipe),
    .flag_clr(clr), .core_flag(cf), .per_flag(pf));

  initial begin
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic t_wipe();
    @(posedge clk) wipe <= 1'b1;
    @(posedge clk) wipe <= 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_short();
    @(posedge clk) instr <= 1'b1;
    @(posedge clk) instr <= 1'b0;
    @(negedge clk) chk("short c1", {halt, pwe, done, res}, 4'h8);
    @(negedge clk) chk("short c2", {halt, pwe, done, res}, 4'h8);
    @(negedge clk) chk("short c3", {halt, pwe, done, res}, 4'h3);
  endtask

  // Disabled decoy flags first, then the terminating source
  task automatic t_long(input logic g, input logic [2:0] c_en, input logic [15:0] p_en,
                        input logic [2:0] c_fl, input logic [15:0] p_fl, input logic [2:0] k);
    @(posedge clk) begin
      gid   <= g;
      ce    <= c_en;
      pe    <= p_en;
      instr <= 1'b1;
    end
    @(posedge clk) instr <= 1'b0;
    @(posedge clk) begin
      cs <= ~c_en;
      ps <= ~p_en;
    end
    @(posedge clk) begin
      cs <= 3'h0;
      ps <= 16'h0000;
    end
    repeat (3) @(posedge clk);
    @(negedge clk) chk("held", {halt, pwe, done}, 3'h6);
    @(posedge clk) begin
      cs <= c_fl;
      ps <= p_fl;
    end
    @(posedge clk) begin
      cs <= 3'h0;
      ps <= 16'h0000;
    end
    @(posedge clk);
    @(negedge clk) chk("end", {halt, pwe, done, vec, res, clr}, {3'h1, ~g, g, k});
    @(negedge clk) chk("flags", {cf, pf}, {(~c_en | c_fl) & ~k, ~p_en | p_fl});
    t_wipe();
  endtask

  task automatic t_abort();
    @(posedge clk) begin
      ce <= 3'h7;
      cs <= 3'h6;
    end
    @(posedge clk) begin
      cs    <= 3'h0;
      instr <= 1'b1;
    end
    @(posedge clk) instr <= 1'b0;
    @(negedge clk) chk("abort", {halt, done, vec, res, abt, clr}, {5'h01, 3'h2});
    t_wipe();
  endtask

  // Reset in mid write ends it with no pulses
  task automatic t_reset_mid();
    @(posedge clk) begin
      gid   <= 1'b0;
      ce    <= 3'h1;
      pe    <= 16'h0000;
      instr <= 1'b1;
    end
    @(posedge clk) instr <= 1'b0;
    @(negedge clk) chk("pre reset", {halt, pwe}, 2'h3);
    @(posedge clk) rst <= 1'b1;
    @(negedge clk) chk("in reset", {halt, pwe, done, vec, res, abt, clr}, 9'h000);
    @(posedge clk) rst <= 1'b0;
    @(negedge clk) chk("reset c1", {halt, pwe, done, vec, res, abt, clr}, 9'h000);
    @(negedge clk) chk("reset c2", {halt, pwe, done, vec, res, abt, clr}, 9'h000);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_short();
    @(posedge clk) vpp <= 1'b1;
    repeat (5) @(posedge clk);
    t_long(1'b0, 3'h1, 16'h0000, 3'h1, 16'h0000, 3'h1);
    t_long(1'b1, 3'h4, 16'h0000, 3'h4, 16'h0000, 3'h4);
    t_long(1'b0, 3'h7, 16'h0000, 3'h6, 16'h0000, 3'h2);
    t_long(1'b0, 3'h0, 16'h0020, 3'h0, 16'h0020, 3'h0);
    t_long(1'b1, 3'h0, 16'h8000, 3'h0, 16'h8000, 3'h0);
    t_abort();
    t_reset_mid();
    conclude();
  end
endmodule // testbench
